// *** hw/dpr_pkg.sv ***
// What this block does
// - Independent mode: each port on own clock
// - Per-port clock enable and clear, port-local
// - Port registers except rden obey their synchronous clear
// - In/out mode: input and output clocks split
// - In/out mode: separate enables and clears
// - Simple dual-port: read-enable register never cleared
// - Read/write mode: write clock registers write side
// - Read/write mode: read clock registers read side
// - Read/write mode: per-clock enables, per-side clears
// - Single-port: two halves, each within 2K bits
// - Write enable selects read or write
// - Byte enables gate writes, default all ones
// - Output register bypass by configuration
package dpr_pkg;

  typedef enum logic [1:0] {
    DPR_INDEPENDENT,
    DPR_IN_OUT,
    DPR_READ_WRITE,
    DPR_SINGLE_PORT
  } dpr_mode_t;

  localparam int DATA_W               = 32;
  localparam int BE_W                 = DATA_W / 8;
  localparam int ADDR_W               = 7;
  localparam int DEPTH                = 1 << ADDR_W;
  localparam int MID_SIZE_BLOCK_BITS  = 4096;
  localparam int SINGLE_PORT_MAX_BITS = 2048;
  localparam int NUM_CLK              = 4;
  localparam int CNT_W                = 16;

  // Avalon register map, word indices decoded from avs_address[3:2]
  localparam int          BUS_ADDR_W = 4;
  localparam logic [1:0]  REG_CTRL   = 2'h0;
  localparam logic [1:0]  REG_STATUS = 2'h1;
  localparam logic [1:0]  REG_WCNT_A = 2'h2;
  localparam logic [1:0]  REG_WCNT_B = 2'h3;
  localparam int          CTRL_BYP_A = 0;
  localparam int          CTRL_BYP_B = 1;
  localparam int          STAT_MODE  = 0;
  localparam int          STAT_SIMPLE = 2;
  localparam int          STAT_PEND_A = 3;
  localparam int          STAT_PEND_B = 4;
  localparam logic [1:0]  CTRL_RESET = 2'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0]   be;
    logic              we;
    logic              rden;
  } dpr_req_t;

  localparam logic [BE_W-1:0] BE_ALL = {BE_W{1'b1}};

endpackage

// *** hw/dpr_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpr_port
  import dpr_pkg::*;
#(
  parameter bit HAS_RDEN = 1'b0,
  parameter bit CAN_READ = 1'b1
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire dpr_req_t          req,
  input  wire logic              in_ev,
  input  wire logic              in_clr,
  input  wire logic              out_ev,
  input  wire logic              out_clr,
  input  wire logic              bypass,
  input  wire logic [DATA_W-1:0] rd_word,
  output dpr_req_t               q,
  output logic                   wr_fire,
  output logic [DATA_W-1:0]      dout
);

  logic [DATA_W-1:0] dout_reg;
  logic              rd_ok;

  // Input side registers: clear wins over the clock event
  always_ff @(posedge clk) begin
    if (rst || in_clr) begin
      q.addr <= '0;
      q.data <= '0;
      q.be   <= BE_ALL;
      q.we   <= 1'b0;
    end else if (in_ev) begin
      q.addr <= req.addr;
      q.data <= req.data;
      q.be   <= req.be;
      q.we   <= req.we;
    end
    // Read enable ignores the clear, only reset touches it
    if (rst) begin
      q.rden <= 1'b0;
    end else if (in_ev) begin
      q.rden <= HAS_RDEN ? req.rden : 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || in_clr) begin
      wr_fire <= 1'b0;
    end else begin
      wr_fire <= in_ev & req.we;
    end
  end

  // No write means read on true ports; rden on simple read port
  assign rd_ok = CAN_READ && (HAS_RDEN ? q.rden : !q.we);

  always_ff @(posedge clk) begin
    if (rst || out_clr) begin
      dout_reg <= '0;
    end else if (out_ev && rd_ok) begin
      dout_reg <= rd_word;
    end
  end

  // Bypass shows the array word one output stage earlier
  assign dout = bypass ? rd_word : dout_reg;

endmodule
`default_nettype wire

// *** hw/dpr_ram.sv ***
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dpr_ram
  import dpr_pkg::*;
#(
  parameter dpr_mode_t MODE   = DPR_INDEPENDENT,
  parameter bit        SIMPLE = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [NUM_CLK-1:0]    clk_tick,
  input  wire logic [NUM_CLK-1:0]    clk_en,
  input  wire logic [NUM_CLK-1:0]    clr,
  input  wire dpr_req_t              req_a,
  input  wire dpr_req_t              req_b,
  output logic [DATA_W-1:0]          dout_a,
  output logic [DATA_W-1:0]          dout_b,
  input  wire logic [BUS_ADDR_W-1:0] avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest
);

  // Mode is a build-time constant; no run-time path alters it
  localparam bit IS_SIMPLE = (MODE == DPR_READ_WRITE) ||
                             (MODE == DPR_IN_OUT && SIMPLE);
  localparam int A_IN  = 0;
  localparam int A_OUT = (MODE == DPR_IN_OUT) ? 1 : 0;
  localparam int B_IN  = (MODE == DPR_IN_OUT) ? 2 : 1;
  localparam int B_OUT = (MODE == DPR_IN_OUT) ? 3 : 1;
  localparam bit SPLIT = (MODE == DPR_SINGLE_PORT);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [NUM_CLK-1:0] ev;
  dpr_req_t          ra;
  dpr_req_t          rb;
  dpr_req_t          qa;
  dpr_req_t          qb;
  logic              fire_a;
  logic              fire_b;
  logic [DATA_W-1:0] word_a;
  logic [DATA_W-1:0] word_b;
  logic [1:0]        ctrl;
  logic [CNT_W-1:0]  wcnt_a;
  logic [CNT_W-1:0]  wcnt_b;
  logic              ack;
  logic              req_any;
  logic [31:0]       next_rdata;

  // Clock tick gated by its own enable
  assign ev = clk_tick & clk_en;

  // Simple dual-port: A writes only, B reads only
  always_comb begin
    ra = req_a;
    rb = req_b;
    if (IS_SIMPLE) begin
      rb.we = 1'b0;
    end
    if (SPLIT) begin
      // Each half stays within the single-port size limit
      ra.addr[ADDR_W-1] = 1'b0;
      rb.addr[ADDR_W-1] = 1'b1;
    end
  end

  dpr_port #(
    .HAS_RDEN (1'b0),
    .CAN_READ (!IS_SIMPLE)
  ) u_port_a (
    .clk     (clk),
    .rst     (rst),
    .req     (ra),
    .in_ev   (ev[A_IN]),
    .in_clr  (clr[A_IN]),
    .out_ev  (ev[A_OUT]),
    .out_clr (clr[A_OUT]),
    .bypass  (ctrl[CTRL_BYP_A]),
    .rd_word (word_a),
    .q       (qa),
    .wr_fire (fire_a),
    .dout    (dout_a)
  );

  dpr_port #(
    .HAS_RDEN (IS_SIMPLE),
    .CAN_READ (1'b1)
  ) u_port_b (
    .clk     (clk),
    .rst     (rst),
    .req     (rb),
    .in_ev   (ev[B_IN]),
    .in_clr  (clr[B_IN]),
    .out_ev  (ev[B_OUT]),
    .out_clr (clr[B_OUT]),
    .bypass  (ctrl[CTRL_BYP_B]),
    .rd_word (word_b),
    .q       (qb),
    .wr_fire (fire_b),
    .dout    (dout_b)
  );

  assign word_a = mem[qa.addr];
  assign word_b = mem[qb.addr];

  // Array write; on a shared byte port A lands last and wins
  always_ff @(posedge clk) begin
    for (int i = 0; i < BE_W; i++) begin
      if (fire_b && qb.be[i]) begin
        mem[qb.addr][i*8 +: 8] <= qb.data[i*8 +: 8];
      end
      if (fire_a && qa.be[i]) begin
        mem[qa.addr][i*8 +: 8] <= qa.data[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wcnt_a <= '0;
    end else if (fire_a) begin
      wcnt_a <= wcnt_a + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wcnt_b <= '0;
    end else if (fire_b) begin
      wcnt_b <= wcnt_b + CNT_W'(1);
    end
  end

  // Avalon slave: fixed one wait state per access
  assign req_any         = avs_read | avs_write;
  assign avs_waitrequest = req_any & ~ack;

  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req_any & ~ack;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
    end else if (avs_write && ack && avs_address[3:2] == REG_CTRL) begin
      ctrl <= avs_writedata[1:0];
    end
  end

  always_comb begin
    next_rdata = '0;
    case (avs_address[3:2])
      REG_CTRL: begin
        next_rdata[1:0] = ctrl;
      end
      REG_STATUS: begin
        next_rdata[STAT_MODE +: 2] = MODE;
        next_rdata[STAT_SIMPLE]    = IS_SIMPLE;
        next_rdata[STAT_PEND_A]    = qa.we;
        next_rdata[STAT_PEND_B]    = qb.we | qb.rden;
      end
      REG_WCNT_A: begin
        next_rdata[CNT_W-1:0] = wcnt_a;
      end
      REG_WCNT_B: begin
        next_rdata[CNT_W-1:0] = wcnt_b;
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack) begin
      avs_readdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// *** sim/dpr_ram_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpr_ram_monitor
  import dpr_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [NUM_CLK-1:0] clk_tick,
  input wire logic [NUM_CLK-1:0] clk_en,
  input wire logic [NUM_CLK-1:0] clr,
  input wire logic [DATA_W-1:0]  dout_a,
  input wire logic [DATA_W-1:0]  dout_b,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_readdata,
  input wire logic               avs_waitrequest
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("wait");
  a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("no wait");
  a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("idle wait");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata)) else $error("readdata moved");
  a_clr_a_zero: assert property (clr[0] |=> dout_a == '0) else $error("a not cleared");
  a_clr_b_zero: assert property (clr[1] |=> dout_b == '0) else $error("b not cleared");
  // Port A only: port B runs with its output bypass, which follows the array live
  a_hold_a: assert property (!(clk_tick[0] && clk_en[0]) && !clr[0] |=> $stable(dout_a)) else $error("a moved");
  a_clr_local: assert property (clr[0] && !clr[1] && !clk_tick[1] |=> $stable(dout_b)) else $error("b hit");
  cover property (clr[0]);
  cover property (avs_write && !avs_waitrequest);
  cover property (clk_tick[0] && !clk_en[0]);
endmodule
`default_nettype wire

// *** sim/dpr_user_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpr_user_model
  import dpr_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  output logic      [NUM_CLK-1:0] clk_tick
);
  logic [1:0] phase;
  // Staggered phases, so no two RAM clocks ever tick together
  always_ff @(posedge clk) begin
    if (rst) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end
  assign clk_tick = 4'h1 << phase;
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
  import dpr_pkg::*;
;
  // Idle request is a read, so no stray write lands after reset
  localparam dpr_req_t   IDLE_REQ = '{7'h0, 32'h0, 4'hf, 1'b0, 1'b0};
  logic                  clk = 1'b0;
  logic                  rst = 1'b1;
  logic [NUM_CLK-1:0]    clk_tick;
  logic [NUM_CLK-1:0]    clk_en = 4'hf;
  logic [NUM_CLK-1:0]    clr = 4'h0;
  dpr_req_t              req_a = IDLE_REQ;
  dpr_req_t              req_b = IDLE_REQ;
  logic [DATA_W-1:0]     dout_a;
  logic [DATA_W-1:0]     dout_b;
  logic [DATA_W-1:0]     dout_a_rw;
  logic [DATA_W-1:0]     dout_b_rw;
  logic [BUS_ADDR_W-1:0] avs_address = 4'h0;
  logic                  avs_read = 1'b0;
  logic                  avs_write = 1'b0;
  logic [31:0]           avs_writedata = 32'h0;
  logic [31:0]           avs_readdata;
  logic [31:0]           rv;
  logic                  avs_waitrequest;
  int                    bad_count = 0;
  int                    compares = 0;
  int                    cycles = 0;
  always #2 clk = ~clk;
  dpr_user_model u_dpr_user_model (.clk(clk), .rst(rst), .clk_tick(clk_tick));
  dpr_ram u_dpr_ram (.clk(clk), .rst(rst), .clk_tick(clk_tick), .clk_en(clk_en), .clr(clr), .req_a(req_a),
    .req_b(req_b), .dout_a(dout_a), .dout_b(dout_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // Same stimulus into a read/write mode copy: A side writes only, B side reads only
  dpr_ram #(.MODE(DPR_READ_WRITE), .SIMPLE(1'b0)) u_dpr_ram_rw (.clk(clk), .rst(rst), .clk_tick(clk_tick),
    .clk_en(clk_en), .clr(clr), .req_a(req_a), .req_b(req_b), .dout_a(dout_a_rw), .dout_b(dout_b_rw),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(), .avs_waitrequest());
  task automatic note(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Port outputs looked at mid-cycle, clear of the launching edge
  task automatic chk_dout(input int sel, input logic [31:0] exp);
    @(negedge clk);
    case (sel)
      0: note(dout_a, exp);
      1: note(dout_b, exp);
      2: note(dout_a_rw, exp);
      default: note(dout_b_rw, exp);
    endcase
  endtask
  task automatic chk_reg(input logic [31:0] exp);
    note(rv, exp);
  endtask
  // One request held for exactly four edges: one event of every RAM clock
  // Reads carry rden for the simple read port
  task automatic op(input bit b, input logic w, input logic [6:0] ad, input logic [31:0] d, input logic [3:0] e);
    @(posedge clk);
    if (b) req_b <= '{ad, d, e, w, !w};
    else req_a <= '{ad, d, e, w, !w};
    repeat (3) @(posedge clk);
  endtask
  task automatic wr(input bit b, input logic [6:0] ad, input logic [31:0] d, input logic [3:0] e);
    op(b, 1'b1, ad, d, e);
    op(b, 1'b0, ad, d, e);
  endtask
  task automatic rd(input bit b, input logic [6:0] ad);
    repeat (3) op(b, 1'b0, ad, 32'h0, BE_ALL);
  endtask
  // Waits as long as the slave asks; only the bench timeout ends a hang
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wr(0, 7'h05, 32'h11223344, BE_ALL);
    rd(0, 7'h05);
    chk_dout(0, 32'h11223344);
    wr(0, 7'h05, 32'haabbccdd, 4'h5);
    chk_dout(0, 32'h11223344);
    rd(0, 7'h05);
    chk_dout(0, 32'h11bb33dd);
    rd(1, 7'h05);
    chk_dout(1, 32'h11bb33dd);
    chk_dout(3, 32'h11bb33dd);
    chk_dout(2, 32'h0);
    $display("test byte enables done");
    wr(1, 7'h09, 32'h5a5a5a5a, BE_ALL);
    rd(0, 7'h09);
    chk_dout(0, 32'h5a5a5a5a);
    rd(1, 7'h09);
    chk_dout(1, 32'h5a5a5a5a);
    @(posedge clk) clk_en <= 4'he;
    wr(0, 7'h05, 32'h0, BE_ALL);
    @(posedge clk) clk_en <= 4'hf;
    rd(0, 7'h05);
    chk_dout(0, 32'h11bb33dd);
    @(posedge clk) clr <= 4'h1;
    @(posedge clk);
    chk_dout(0, 32'h0);
    chk_dout(1, 32'h5a5a5a5a);
    @(posedge clk) clr <= 4'h2;
    @(posedge clk);
    chk_dout(1, 32'h0);
    @(posedge clk) clr <= 4'h0;
    $display("test ports done");
    bus(1'b1, 4'h4, 32'hffffffff);
    bus(1'b0, 4'h4, 32'h0);
    chk_reg(32'h0);
    bus(1'b1, 4'h0, 32'h2);
    bus(1'b0, 4'h0, 32'h0);
    chk_reg(32'h2);
    rd(1, 7'h09);
    wr(1, 7'h09, 32'h0f0f0f0f, BE_ALL);
    chk_dout(1, 32'h0f0f0f0f);
    wr(1, 7'h05, 32'h0, BE_ALL);
    chk_dout(1, 32'h0);
    chk_dout(3, 32'h11bb33dd);
    bus(1'b0, 4'h8, 32'h0);
    chk_reg(32'h2);
    bus(1'b0, 4'hc, 32'h0);
    chk_reg(32'h3);
    $display("test bypass done");
    tally_and_finish();
  end
endmodule
bind dpr_ram dpr_ram_monitor u_dpr_ram_monitor (.clk(clk), .rst(rst), .clk_tick(clk_tick), .clk_en(clk_en),
  .clr(clr), .dout_a(dout_a), .dout_b(dout_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
`default_nettype wire
